/* rtu_slave_port.sv */
// RTU slave serial port: framing, addressing, reply timing, loss fault
`timescale 1ns/100ps
`default_nettype none
module rtu_slave_port #(
    parameter int CLK_HZ = mbrtu_pkg::CLK_HZ
) (
    input  wire logic            clk,
    input  wire logic            rst_n,
    input  wire logic            ce,
    input  wire mbrtu_pkg::cfg_t cfg,
    input  wire logic            fault_clear,
    input  wire logic            rxd,
    output logic                 txd,
    output logic                 tx_de,
    output logic           [7:0] rx_data,
    output logic                 rx_valid,
    input  wire logic            rx_ready,
    output mbrtu_pkg::frame_t    frame_o,
    input  wire logic      [7:0] tx_data,
    input  wire logic            tx_last,
    input  wire logic            tx_valid,
    output logic                 tx_ready,
    output mbrtu_pkg::fault_t    fault_o
);
    localparam int MS_CYC = CLK_HZ / mbrtu_pkg::MS_PER_S;

    typedef struct packed {
        logic                 init_done;
        logic [7:0]           addr;
        logic [3:0]           rate;
        logic [1:0]           par;
        logic [1:0]           sync;
        mbrtu_pkg::rx_state_t rx;
        logic [15:0]          rcnt;
        logic [2:0]           rbits;
        logic [7:0]           rsh;
        logic                 rperr;
        logic [5:0]           gap;
        logic                 in_frame;
        logic                 accept;
        logic                 bcast;
        logic                 ferr;
        mbrtu_pkg::frame_t    frm;
        logic [15:0]          mscnt;
        logic [13:0]          loss;
        logic                 fault;
        mbrtu_pkg::fault_t    flt;
        mbrtu_pkg::tx_state_t tx;
        logic [15:0]          tcnt;
        logic [2:0]           tbits;
        logic [7:0]           tsh;
        logic                 tpar;
        logic                 tlast;
        logic [6:0]           dly;
        logic                 txd;
        logic                 de;
    } core_st_t;

    localparam core_st_t ST_RST = '{
        rx:      mbrtu_pkg::RX_IDLE,
        tx:      mbrtu_pkg::TX_IDLE,
        addr:    mbrtu_pkg::ADDR_RST,
        rate:    mbrtu_pkg::RATE_RST,
        par:     mbrtu_pkg::PARITY_RST,
        sync:    2'h3,
        txd:     1'b1,
        default: '0
    };

    core_st_t    r;
    core_st_t    n;
    logic [15:0] bitc;
    logic [15:0] half;
    logic        rxs;
    logic        par_on;
    logic        tick;
    logic        chr_done;
    logic        stop_bad;
    logic        acc_now;
    logic        push;
    logic        push_ready;
    logic [6:0]  rdly;
    logic [6:0]  tmo;
    logic [13:0] lim;

    assign bitc     = mbrtu_pkg::bit_cycles(CLK_HZ, r.rate);
    assign half     = bitc >> 1;
    assign rxs      = r.sync[1];
    assign par_on   = (r.par == mbrtu_pkg::PAR_EVEN)
                   || (r.par == mbrtu_pkg::PAR_ODD);
    assign tick     = (r.mscnt == '0);
    assign tx_ready = (r.tx == mbrtu_pkg::TX_LOAD);
    assign txd      = r.txd;
    assign tx_de    = r.de;
    assign frame_o  = r.frm;
    assign fault_o  = r.flt;

    always_comb begin
        n        = r;
        n.frm    = '0;
        chr_done = 1'b0;
        stop_bad = 1'b0;
        acc_now  = 1'b0;
        push     = 1'b0;
        rdly     = cfg.reply_delay_time;
        tmo      = cfg.link_loss_timeout;
        if (rdly < mbrtu_pkg::REPLY_MS_MIN) begin
            rdly = mbrtu_pkg::REPLY_MS_MIN;
        end else if (rdly > mbrtu_pkg::REPLY_MS_MAX) begin
            rdly = mbrtu_pkg::REPLY_MS_MAX;
        end
        if (tmo > mbrtu_pkg::LOSS_TMO_MAX) begin
            tmo = mbrtu_pkg::LOSS_TMO_MAX;
        end
        lim = 14'(int'(tmo) * mbrtu_pkg::LOSS_UNIT_MS);

        n.mscnt = tick ? 16'(MS_CYC - 1) : r.mscnt - 16'h1;
        n.sync  = {r.sync[0], rxd};
        if (!r.init_done) begin
            n.init_done = 1'b1;
            n.addr      = cfg.own_slave_address;
            n.rate      = cfg.bit_rate_select;
            n.par       = cfg.parity_select;
        end

        // Receiver; the idle branch also measures the inter-frame gap
        unique case (r.rx)
            mbrtu_pkg::RX_IDLE: begin
                if (!rxs) begin
                    n.rx   = mbrtu_pkg::RX_START;
                    n.rcnt = half;
                    n.gap  = '0;
                end else if (r.rcnt == '0) begin
                    n.rcnt = bitc - 16'h1;
                    if (r.gap != mbrtu_pkg::GAP_BITS) begin
                        n.gap = r.gap + 6'h1;
                    end
                end else begin
                    n.rcnt = r.rcnt - 16'h1;
                end
            end
            mbrtu_pkg::RX_START: begin
                if (r.rcnt != '0) begin
                    n.rcnt = r.rcnt - 16'h1;
                end else if (!rxs) begin
                    n.rx    = mbrtu_pkg::RX_DATA;
                    n.rcnt  = bitc - 16'h1;
                    n.rbits = '0;
                    n.rperr = 1'b0;
                end else begin
                    n.rx = mbrtu_pkg::RX_IDLE; // Glitch, not a start bit
                end
            end
            mbrtu_pkg::RX_DATA: begin
                if (r.rcnt != '0) begin
                    n.rcnt = r.rcnt - 16'h1;
                end else begin
                    n.rsh  = {rxs, r.rsh[7:1]};
                    n.rcnt = bitc - 16'h1;
                    n.rbits = r.rbits + 3'h1;
                    if (r.rbits == 3'h7) begin
                        n.rx = par_on ? mbrtu_pkg::RX_PAR
                                      : mbrtu_pkg::RX_STOP;
                    end
                end
            end
            mbrtu_pkg::RX_PAR: begin
                if (r.rcnt != '0) begin
                    n.rcnt = r.rcnt - 16'h1;
                end else begin
                    n.rperr = rxs ^ mbrtu_pkg::par_bit(r.rsh, r.par);
                    n.rcnt  = bitc - 16'h1;
                    n.rx    = mbrtu_pkg::RX_STOP;
                end
            end
            mbrtu_pkg::RX_STOP: begin
                if (r.rcnt != '0) begin
                    n.rcnt = r.rcnt - 16'h1;
                end else begin
                    n.rx     = mbrtu_pkg::RX_IDLE;
                    n.rcnt   = bitc - 16'h1;
                    chr_done = rxs;
                    stop_bad = !rxs;
                end
            end
            default: begin
                n.rx = mbrtu_pkg::RX_IDLE;
            end
        endcase

        if (tick && (r.loss != '1)) begin
            n.loss = r.loss + 14'h1;
        end
        if (chr_done || stop_bad) begin
            n.loss     = '0;
            n.in_frame = 1'b1;
        end
        if (chr_done) begin
            if (!r.in_frame) begin
                acc_now = (r.rsh == r.addr)
                       || (r.rsh == mbrtu_pkg::ADDR_BCAST);
                n.accept = acc_now;
                n.bcast  = (r.rsh == mbrtu_pkg::ADDR_BCAST);
                n.ferr   = r.rperr;
            end else begin
                acc_now = r.accept;
                n.ferr  = r.ferr || r.rperr;
            end
            push = acc_now;
            if (acc_now && !push_ready) begin
                n.ferr = 1'b1; // Overrun spoils the frame
            end
        end
        if (stop_bad) begin
            n.ferr = 1'b1;
            if (!r.in_frame) begin
                n.accept = 1'b0;
            end
        end

        // Frame ends after 35 idle bit times, three and a half characters when parity is off
        if ((r.rx == mbrtu_pkg::RX_IDLE) && rxs && (r.rcnt == '0)
            && (r.gap == mbrtu_pkg::GAP_BITS - 6'h1) && r.in_frame) begin
            n.in_frame  = 1'b0;
            n.frm.done  = r.accept;
            n.frm.good  = !r.ferr;
            n.frm.bcast = r.bcast;
            if (r.accept && !r.ferr && !r.bcast
                && (r.tx == mbrtu_pkg::TX_IDLE)) begin
                n.tx    = mbrtu_pkg::TX_WAIT;
                n.dly   = rdly;
                n.mscnt = 16'(MS_CYC - 1);
            end
        end

        if (fault_clear) begin
            n.fault = 1'b0;
        end
        if (r.loss > lim) begin
            n.fault = 1'b1;
        end
        if (!cfg.link_loss_detect_enable) begin
            n.fault = 1'b0;
        end
        n.flt.active = n.fault;
        n.flt.ramp   = n.fault && (cfg.link_fault_stop_action
                                   == mbrtu_pkg::STOP_RAMP);
        n.flt.fast   = n.fault && (cfg.link_fault_stop_action
                                   == mbrtu_pkg::STOP_FAST);
        n.flt.coast  = n.fault && (cfg.link_fault_stop_action
                                   == mbrtu_pkg::STOP_COAST);
        n.flt.alarm  = n.fault && (cfg.link_fault_stop_action
                                   == mbrtu_pkg::STOP_ALARM);

        // Transmitter
        unique case (r.tx)
            mbrtu_pkg::TX_IDLE: begin
            end
            mbrtu_pkg::TX_WAIT: begin
                if (tick) begin
                    n.dly = r.dly - 7'h1;
                    if (r.dly == 7'h1) begin
                        n.tx = mbrtu_pkg::TX_LOAD;
                    end
                end
            end
            mbrtu_pkg::TX_LOAD: begin
                if (tx_valid) begin
                    n.tsh   = tx_data;
                    n.tpar  = mbrtu_pkg::par_bit(tx_data, r.par);
                    n.tlast = tx_last;
                    n.tcnt  = bitc - 16'h1;
                    n.txd   = 1'b0;
                    n.tx    = mbrtu_pkg::TX_START;
                end
            end
            mbrtu_pkg::TX_START: begin
                if (r.tcnt != '0) begin
                    n.tcnt = r.tcnt - 16'h1;
                end else begin
                    n.tcnt  = bitc - 16'h1;
                    n.tbits = '0;
                    n.txd   = r.tsh[0];
                    n.tx    = mbrtu_pkg::TX_DATA;
                end
            end
            mbrtu_pkg::TX_DATA: begin
                if (r.tcnt != '0) begin
                    n.tcnt = r.tcnt - 16'h1;
                end else begin
                    n.tcnt = bitc - 16'h1;
                    if (r.tbits == 3'h7) begin
                        n.tx  = par_on ? mbrtu_pkg::TX_PAR
                                       : mbrtu_pkg::TX_STOP;
                        n.txd = par_on ? r.tpar : 1'b1;
                    end else begin
                        n.tbits = r.tbits + 3'h1;
                        n.txd   = r.tsh[1];
                        n.tsh   = r.tsh >> 1;
                    end
                end
            end
            mbrtu_pkg::TX_PAR: begin
                if (r.tcnt != '0) begin
                    n.tcnt = r.tcnt - 16'h1;
                end else begin
                    n.tcnt = bitc - 16'h1;
                    n.txd  = 1'b1;
                    n.tx   = mbrtu_pkg::TX_STOP;
                end
            end
            mbrtu_pkg::TX_STOP: begin
                if (r.tcnt != '0) begin
                    n.tcnt = r.tcnt - 16'h1;
                end else begin
                    n.tx = r.tlast ? mbrtu_pkg::TX_IDLE
                                   : mbrtu_pkg::TX_LOAD;
                end
            end
            default: begin
                n.tx  = mbrtu_pkg::TX_IDLE;
                n.txd = 1'b1;
            end
        endcase
        n.de = !cfg.driver_enable_control
            || !((n.tx == mbrtu_pkg::TX_IDLE)
                 || (n.tx == mbrtu_pkg::TX_WAIT));
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r <= ST_RST;
        end else if (ce) begin
            r <= n;
        end
    end

    byte_fifo #(
        .WIDTH (mbrtu_pkg::DATA_BITS),
        .DEPTH (mbrtu_pkg::FIFO_DEPTH)
    ) u_rx_fifo (
        .clk       (clk),
        .rst_n     (rst_n),
        .ce        (ce),
        .in_valid  (push),
        .in_ready  (push_ready),
        .in_data   (r.rsh),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );

    // Cycles spent in the reply wait, for the timing check
    int         wait_cyc;
    logic [6:0] dly_cap;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wait_cyc <= 0;
            dly_cap  <= '0;
        end else if (ce) begin
            wait_cyc <= (r.tx == mbrtu_pkg::TX_WAIT) ? wait_cyc + 1 : 0;
            if (r.tx != mbrtu_pkg::TX_WAIT) begin
                dly_cap <= n.dly;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n || !ce);

    chk_de_forced: assert property (
        !cfg.driver_enable_control |=> tx_de)
        else $error("driver enable dropped while forced on");
    chk_de_idle: assert property (
        cfg.driver_enable_control && (r.tx == mbrtu_pkg::TX_IDLE)
        |=> !tx_de)
        else $error("driver enabled while not sending");
    chk_line_idle: assert property (
        (r.tx == mbrtu_pkg::TX_IDLE) || (r.tx == mbrtu_pkg::TX_WAIT)
        |-> txd)
        else $error("line not marking outside a reply");
    chk_tx_cause: assert property (
        ($past(r.tx) == mbrtu_pkg::TX_IDLE)
        && (r.tx != mbrtu_pkg::TX_IDLE)
        |-> frame_o.done && frame_o.good && !frame_o.bcast)
        else $error("transmit started without a command");
    chk_bcast_quiet: assert property (
        frame_o.done && frame_o.bcast
        && ($past(r.tx) == mbrtu_pkg::TX_IDLE)
        |-> (r.tx == mbrtu_pkg::TX_IDLE))
        else $error("reply to a broadcast");
    chk_bad_quiet: assert property (
        frame_o.done && !frame_o.good
        && ($past(r.tx) == mbrtu_pkg::TX_IDLE)
        |-> (r.tx == mbrtu_pkg::TX_IDLE)[*2])
        else $error("reply to a faulty frame");
    chk_reply_wait: assert property (
        (r.tx == mbrtu_pkg::TX_WAIT) && (n.tx == mbrtu_pkg::TX_LOAD)
        |-> (wait_cyc == int'(dly_cap) * MS_CYC - 1))
        else $error("reply wait length wrong");
    chk_fault_off: assert property (
        !cfg.link_loss_detect_enable |=> !fault_o.active)
        else $error("fault raised with detection disabled");
    chk_fault_on: assert property (
        cfg.link_loss_detect_enable && (r.loss > lim) |=> fault_o.active)
        else $error("silence timeout did not raise fault");
    chk_loss_restart: assert property (
        chr_done |=> (r.loss == '0))
        else $error("loss timer not restarted by character");
    chk_cfg_frozen: assert property (
        r.init_done |=> $stable(r.addr) && $stable(r.rate)
                        && $stable(r.par))
        else $error("latched settings changed after init");
    chk_action_onehot: assert property (
        fault_o.active |-> $onehot({fault_o.ramp, fault_o.fast,
                                    fault_o.coast, fault_o.alarm}))
        else $error("fault action not exactly one");
    chk_no_parity: assert property (
        !par_on |-> (r.rx != mbrtu_pkg::RX_PAR)
                    && (r.tx != mbrtu_pkg::TX_PAR))
        else $error("parity slot used with parity off");

    cov_reply: cover property (
        (r.tx == mbrtu_pkg::TX_STOP) ##1 (r.tx == mbrtu_pkg::TX_IDLE));
    cov_bcast: cover property (frame_o.done && frame_o.bcast);
    cov_bad_frame: cover property (frame_o.done && !frame_o.good);
    cov_fault: cover property ($rose(fault_o.active));
endmodule : rtu_slave_port
`default_nettype wire

/* mbrtu_pkg.sv */
// Constants, carriers and states of the RTU slave serial port
// How it works
// - Slave only: transmits solely as the reply to an accepted command.
// - Start bit, eight data bits LSB first, optional parity, one stop.
// - Parity code 0 none, 1 even, 2 odd; default none.
// - Rate code 0..8 picks 1200 to 115200 bit/s; default 9600.
// - Own slave address accepts commands; default 1F hex.
// - Address, rate and parity are latched only at initialisation.
// - Enabled loss detection raises the fault after silence past timeout.
// - Disabled loss detection never raises the fault.
// - Fault action: 0 ramp, 1 fast, 2 coast, 3 alarm only.
// - Reply starts after programmed wait of 5 to 65 ms.
// - Driver control 0 keeps the driver enable permanently on.
// - Driver control 1 enables the driver only while transmitting.
// - Loss timeout 0.0 to 10.0 s in tenths, default 2.0 s.
// - Address 0 is broadcast: accepted, never answered.
`default_nettype none
package mbrtu_pkg;
    localparam int          CLK_HZ          = 40_000_000;
    localparam int          MS_PER_S        = 1000;
    localparam int          LOSS_UNIT_MS    = 100;
    localparam logic [5:0]  GAP_BITS        = 6'h23;
    localparam int          FIFO_DEPTH      = 16;
    localparam int          DATA_BITS       = 8;
    localparam logic [7:0]  ADDR_RST        = 8'h1F;
    localparam logic [7:0]  ADDR_BCAST      = 8'h00;
    localparam logic [3:0]  RATE_RST        = 4'h3;
    localparam logic [1:0]  PARITY_RST      = 2'h0;
    localparam logic [1:0]  ACTION_RST      = 2'h3;
    localparam logic        LOSS_EN_RST     = 1'b1;
    localparam logic [6:0]  REPLY_MS_RST    = 7'h05;
    localparam logic [6:0]  REPLY_MS_MIN    = 7'h05;
    localparam logic [6:0]  REPLY_MS_MAX    = 7'h41;
    localparam logic        DE_CTRL_RST     = 1'b1;
    localparam logic [6:0]  LOSS_TMO_RST    = 7'h14;
    localparam logic [6:0]  LOSS_TMO_MAX    = 7'h64;

    typedef enum logic [1:0] {
        PAR_NONE = 2'h0,
        PAR_EVEN = 2'h1,
        PAR_ODD  = 2'h2
    } parity_t;

    typedef enum logic [1:0] {
        STOP_RAMP  = 2'h0,
        STOP_FAST  = 2'h1,
        STOP_COAST = 2'h2,
        STOP_ALARM = 2'h3
    } stop_action_t;

    typedef enum logic [2:0] {
        RX_IDLE  = 3'h0,
        RX_START = 3'h1,
        RX_DATA  = 3'h3,
        RX_PAR   = 3'h2,
        RX_STOP  = 3'h6
    } rx_state_t;

    typedef enum logic [2:0] {
        TX_IDLE  = 3'h0,
        TX_WAIT  = 3'h1,
        TX_LOAD  = 3'h3,
        TX_START = 3'h2,
        TX_DATA  = 3'h6,
        TX_PAR   = 3'h7,
        TX_STOP  = 3'h5
    } tx_state_t;

    typedef struct packed {
        logic [7:0] own_slave_address;
        logic [3:0] bit_rate_select;
        logic [1:0] parity_select;
        logic [1:0] link_fault_stop_action;
        logic       link_loss_detect_enable;
        logic [6:0] reply_delay_time;
        logic       driver_enable_control;
        logic [6:0] link_loss_timeout;
    } cfg_t;

    typedef struct packed {
        logic done;
        logic good;
        logic bcast;
    } frame_t;

    typedef struct packed {
        logic active;
        logic ramp;
        logic fast;
        logic coast;
        logic alarm;
    } fault_t;

    function automatic logic [15:0] bit_cycles(input int clk_hz,
                                               input logic [3:0] sel);
        int baud;
        case (sel)
            4'h0: baud = 1200;
            4'h1: baud = 2400;
            4'h2: baud = 4800;
            4'h4: baud = 19200;
            4'h5: baud = 38400;
            4'h6: baud = 57600;
            4'h7: baud = 76800;
            4'h8: baud = 115200;
            default: baud = 9600;
        endcase
        return 16'(clk_hz / baud);
    endfunction : bit_cycles

    function automatic logic par_bit(input logic [7:0] d,
                                     input logic [1:0] sel);
        return (sel == PAR_ODD) ? ~^d : ^d;
    endfunction : par_bit
endpackage : mbrtu_pkg
`default_nettype wire

/* byte_fifo.sv */
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } fifo_st_t;

    fifo_st_t         r;
    fifo_st_t         n;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    assign in_ready  = (r.cnt != (AW+1)'(DEPTH));
    assign out_valid = (r.cnt != '0);
    assign out_data  = mem[r.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        n = r;
        if (push) begin
            n.wp = AW'(r.wp + 1'b1);
        end
        if (pop) begin
            n.rp = AW'(r.rp + 1'b1);
        end
        n.cnt = (AW+1)'(r.cnt + push - pop);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r <= '0;
        end else if (ce) begin
            r <= n;
        end
    end

    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem[r.wp] <= in_data;
        end
    end

    chk_fifo_bound: assert property (@(posedge clk) disable iff (!rst_n)
        r.cnt <= (AW+1)'(DEPTH))
        else $error("fifo count beyond depth");
endmodule : byte_fifo
`default_nettype wire

/* rtu_master.sv */
// Master model: sends characters to the port and collects its reply
`timescale 1ns/100ps
`default_nettype none
module rtu_master #(
    parameter int BITC = 10
) (
    input  wire logic clk,
    output var logic  line_o,
    input  wire logic line_i
);
    logic [7:0] got[$];
    logic [1:0] par_mode = 2'h1;
    initial line_o = 1'b1;
    // Start, eight data LSB first, parity per par_mode (bad flips it), stop
    task automatic send(input logic [7:0] d, input bit bad);
        logic [10:0] f;
        f = {1'b1, ^d ^ (par_mode == 2'h2) ^ bad, d, 1'b0};
        if (par_mode == 2'h0) begin
            f = {2'b11, d, 1'b0};
        end
        for (int i = 0; i < 11 - int'(par_mode == 2'h0); i++) begin
            @(posedge clk) line_o <= f[i];
            repeat (BITC - 1) @(posedge clk);
        end
    endtask : send
    always begin : rx_catch
        logic [7:0] d;
        @(negedge line_i);
        repeat (BITC + BITC / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            d[i] = line_i;
            repeat (BITC) @(posedge clk);
        end
        got.push_back(d);
        repeat (BITC) @(posedge clk);
    end
endmodule : rtu_master
`default_nettype wire

/* tb_top.sv */
// Bench for the RTU slave port: frames, replies, loss fault, driver
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam int MS = 1152;
    logic clk = 1'b0, rst_n, ce, fault_clear, rxd, txd, tx_de;
    logic rx_valid, rx_ready, tx_last, tx_valid, tx_ready;
    logic [7:0] rx_data, tx_data;
    logic [7:0] rxq[$];
    mbrtu_pkg::cfg_t   cfg;
    mbrtu_pkg::frame_t frame_o;
    mbrtu_pkg::fault_t fault_o;
    int fail_count = 0, n_checks = 0, k;
    always #12.5 clk = ~clk;
    rtu_slave_port #(.CLK_HZ(1_152_000)) i_dut (.clk, .rst_n, .ce, .cfg,
        .fault_clear, .rxd, .txd, .tx_de, .rx_data, .rx_valid, .rx_ready,
        .frame_o, .tx_data, .tx_last, .tx_valid, .tx_ready, .fault_o);
    rtu_master #(.BITC(10)) i_master (.clk, .line_o(rxd), .line_i(txd));
    always @(posedge clk) if (rx_valid && rx_ready) rxq.push_back(rx_data);
    task automatic end_sim;
        $display("checks %0d errors %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_sim
    task automatic chk(input string s, input logic [15:0] e, g);
        n_checks++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", s, e, g);
            fail_count++;
        end
    endtask : chk
    function automatic logic pick(input int s);
        return s == 0 ? frame_o.done : s == 1 ? tx_ready : fault_o.active;
    endfunction : pick
    task automatic wait_on(input int s, input int n, input bit must);
        k = 0;
        while (pick(s) !== 1'b1 && k < n) begin
            @(posedge clk);
            #1;
            k++;
        end
        if (must && pick(s) !== 1'b1) begin
            $display("ERROR wait %0d expected 1 seen 0", s);
            fail_count++;
            end_sim();
        end
    endtask : wait_on
    // One slave addressed per frame
    task automatic frame(input logic [7:0] a, b, input bit bad);
        i_master.send(a, 1'b0);
        i_master.send(b, bad);
        wait_on(0, 600, 1'b0);
    endtask : frame
    initial begin
        {rst_n, fault_clear, tx_valid, tx_last, tx_data} = '0;
        ce = 1'b1;
        rx_ready = 1'b1;
        cfg = {8'h1F, 4'h8, 2'h1, 2'h3, 1'b0, 7'h05, 1'b1, 7'h00};
        repeat (12) @(posedge clk);
        #1;
        chk("idle", 16'h0001, {tx_de, rx_valid, frame_o, fault_o, txd});
        @(posedge clk) rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        cfg.own_slave_address <= 8'h22;
        frame(8'h1F, 8'hA5, 1'b0);
        chk("frame", 16'h0006, {tx_de, frame_o});
        wait_on(1, 6000, 1'b1);
        chk("wait", 16'h0001, 16'(k >= 5 * MS - 2 && k <= 5 * MS + 2));
        chk("de on", 16'h0001, 16'(tx_de));
        @(posedge clk) {tx_valid, tx_last, tx_data} <= {2'b11, 8'h3C};
        @(posedge clk) tx_valid <= 1'b0;
        repeat (120) @(posedge clk);
        #1;
        chk("reply", 16'h013C,
            {tx_de, i_master.got.size() == 1, i_master.got[0]});
        chk("rx bytes", 16'h1FA5, {rxq[0], rxq[1]});
        frame(8'h00, 8'h55, 1'b0);
        chk("bcast", 16'h0007, {tx_de, frame_o});
        wait_on(1, 6000, 1'b0);
        chk("bcast reply", 16'h0000, {tx_de, tx_ready});
        rxq.delete();
        frame(8'h07, 8'h1F, 1'b0);
        chk("foreign", 16'h0000, {frame_o.done, 8'(rxq.size())});
        frame(8'h1F, 8'h11, 1'b1);
        chk("bad parity", 16'h0004, {tx_de, frame_o});
        wait_on(1, 6000, 1'b0);
        chk("bad reply", 16'h0000, {tx_de, tx_ready});
        chk("no fault", 16'h0000, 16'(fault_o));
        for (int a = 0; a < 4; a++) begin
            @(posedge clk) cfg.link_fault_stop_action <= 2'(a);
            cfg.link_loss_detect_enable <= 1'b1;
            wait_on(2, 1500, 1'b1);
            chk("action", 16'h0010 | (16'h0008 >> a), 16'(fault_o));
            @(posedge clk) cfg.link_loss_detect_enable <= 1'b0;
            repeat (2) @(posedge clk);
            #1;
            chk("disabled", 16'h0000, 16'(fault_o));
        end
        // Mid-run reset relatches parity and the address changed earlier
        for (int p = 0; p < 3; p += 2) begin
            @(posedge clk) {rst_n, cfg.parity_select} <= {1'b0, 2'(p)};
            i_master.par_mode = 2'(p);
            @(posedge clk) rst_n <= 1'b1;
            repeat (2) @(posedge clk);
            rxq.delete();
            frame(8'h22, 8'h5A, 1'b0);
            chk("new mode", 16'h0006, {tx_de, frame_o});
            chk("new bytes", 16'h225A, {rxq[0], rxq[1]});
        end
        @(posedge clk) cfg.driver_enable_control <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk("de forced", 16'h0001, 16'(tx_de));
        end_sim();
    end
    initial begin
        repeat (60000) @(posedge clk);
        $display("ERROR run expected end seen timeout");
        fail_count++;
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
